// ==== rtl/term_sel.sv ====
// Purpose: Select the condition that drives one digital output terminal
// Assumes: Status inputs come from engines in other clock domains or pins
// Notes:   Registers reached over APB; one level interrupt output
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// How it works
// - Code 14 asserts when wobble frequency exceeds upper or lower limit.
// - Wobble limit reported only while wobble enable setting is one.
// - Code 15 asserts while the simple PLC sequence runs.
// - Code 16 asserts while PLC is paused from external terminals.
// - Code 17 signals each completed PLC cycle.
// - Code 18 signals each completed PLC step.
// - Code 19 signals when the whole PLC sequence completes.
// - Code 20 follows the communication-written output bit.
// - Code 21 signals when operating time reaches its preset.
// - Codes 17, 18, 19, 21 give a 500 ms pulse per event; an event during a pulse restarts the 500 ms.
// - Code 22 follows the timing function output.
// - Code 23 asserts when the counter reaches the preset count.
// - Code 24 asserts when the counter reaches the indicating count.
// - Code 0 keeps the terminal inactive.
module term_sel (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire term_sel_pkg::status_in_t status_in,
    output logic                          term_out,
    output logic                          irq
);
    import term_sel_pkg::*;

    // Synchronisers for asynchronous status sources
    status_in_t sync1_reg;
    status_in_t sync2_reg;
    status_in_t sync_prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg     <= '0;
            sync2_reg     <= '0;
            sync_prev_reg <= '0;
        end else begin
            sync1_reg     <= status_in;
            sync2_reg     <= sync1_reg;
            sync_prev_reg <= sync2_reg;
        end
    end

    function automatic logic rise(input logic now_v, input logic was_v);
        rise = now_v & ~was_v;
    endfunction

    logic ev_cycle;
    logic ev_step;
    logic ev_done;
    logic ev_time;

    assign ev_cycle = rise(sync2_reg.plc_cycle_done, sync_prev_reg.plc_cycle_done);
    assign ev_step  = rise(sync2_reg.plc_step_done, sync_prev_reg.plc_step_done);
    assign ev_done  = rise(sync2_reg.plc_all_done, sync_prev_reg.plc_all_done);
    assign ev_time  = rise(sync2_reg.run_time_reached, sync_prev_reg.run_time_reached);

    // Register file
    // SEL      selection code of the terminal source
    // CTRL     bit 0 wobble enable setting, bit 1 output value written by the host
    // STATUS   synchronised status, terminal level, pulse active (read only)
    // IRQ_STAT sticky events, write one to clear
    // IRQ_MASK one enables the matching event onto irq
    logic [5:0]  sel_reg;
    logic [5:0]  sel_next;
    logic [1:0]  ctrl_reg;
    logic [1:0]  ctrl_next;
    logic [2:0]  irq_stat_reg;
    logic [2:0]  irq_stat_next;
    logic [2:0]  irq_mask_reg;
    logic [2:0]  irq_mask_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pslverr_reg;
    logic        pslverr_next;

    logic        wr_en;
    logic        rd_setup;
    logic        addr_ok;
    logic        term_next;
    logic        term_reg;
    logic        pulse_out;
    logic        pulse_trig;
    logic [2:0]  irq_events;

    assign wr_en   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign addr_ok = (paddr == OFS_SEL) || (paddr == OFS_CTRL) || (paddr == OFS_STATUS)
                  || (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);
    assign pready  = 1'b1;

    always_comb begin
        sel_next      = sel_reg;
        ctrl_next     = ctrl_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        // Read data and error are captured in the setup cycle
        prdata_next   = 32'h00000000;
        pslverr_next  = psel & ~penable & ~addr_ok;
        if (wr_en) begin
            case (paddr)
                OFS_SEL: begin
                    sel_next = pwdata[5:0];
                end
                OFS_CTRL: begin
                    ctrl_next = pwdata[1:0];
                end
                OFS_IRQ_STAT: begin
                    irq_stat_next = irq_stat_reg & ~pwdata[2:0];
                end
                OFS_IRQ_MASK: begin
                    irq_mask_next = pwdata[2:0];
                end
                default: begin
                    sel_next = sel_reg;     // Read-only or unmapped: write dropped
                end
            endcase
        end
        if (rd_setup) begin
            case (paddr)
                OFS_SEL:      prdata_next = {26'h0000000, sel_reg};
                OFS_CTRL:     prdata_next = {30'h00000000, ctrl_reg};
                OFS_STATUS:   prdata_next = {19'h00000, pulse_out, term_reg, sync2_reg};
                OFS_IRQ_STAT: prdata_next = {29'h00000000, irq_stat_reg};
                OFS_IRQ_MASK: prdata_next = {29'h00000000, irq_mask_reg};
                default:      prdata_next = 32'h00000000;
            endcase
        end
        // Set wins over a clear in the same cycle
        irq_stat_next = irq_stat_next | irq_events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg      <= SEL_RESET;
            ctrl_reg     <= CTRL_RESET;
            irq_stat_reg <= IRQ_RESET;
            irq_mask_reg <= IRQ_RESET;
            prdata_reg   <= 32'h00000000;
            pslverr_reg  <= 1'b0;
        end else begin
            sel_reg      <= sel_next;
            ctrl_reg     <= ctrl_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            prdata_reg   <= prdata_next;
            pslverr_reg  <= pslverr_next;
        end
    end

    // Captured at the setup edge, so both stand unchanged through the access cycle
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    // Event pulse generation for the selected pulse source
    always_comb begin
        case (sel_reg)
            SRC_PLC_CYCLE: pulse_trig = ev_cycle;
            SRC_PLC_STEP:  pulse_trig = ev_step;
            SRC_PLC_DONE:  pulse_trig = ev_done;
            SRC_RUN_TIME:  pulse_trig = ev_time;
            default:       pulse_trig = 1'b0;
        endcase
    end

    pulse_stretch u_pulse (
        .pclk    (pclk),
        .presetn (presetn),
        .trig    (pulse_trig),
        .pulse   (pulse_out)
    );

    // Terminal source multiplexer
    always_comb begin
        case (sel_reg)
            SRC_UNUSED:     term_next = 1'b0;
            SRC_WOBBLE_LIM: term_next = ctrl_reg[CTRL_WOBBLE_EN]
                                      & (sync2_reg.wobble_high | sync2_reg.wobble_low);
            SRC_PLC_RUN:    term_next = sync2_reg.plc_running;
            SRC_PLC_PAUSE:  term_next = sync2_reg.plc_paused;
            SRC_PLC_CYCLE,
            SRC_PLC_STEP,
            SRC_PLC_DONE,
            SRC_RUN_TIME:   term_next = pulse_out;
            SRC_COMM:       term_next = ctrl_reg[CTRL_COMM_OUT];
            SRC_TIMER:      term_next = sync2_reg.timer_out;
            SRC_CNT_PRESET: term_next = sync2_reg.cnt_preset_reached;
            SRC_CNT_IND:    term_next = sync2_reg.cnt_ind_reached;
            default:        term_next = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_reg <= 1'b0;
        end else begin
            term_reg <= term_next;
        end
    end

    assign term_out = term_reg;

    // Interrupt events: terminal rising, pulse start, selection write
    assign irq_events[IRQ_EDGE]  = term_next & ~term_reg;
    assign irq_events[IRQ_PULSE] = pulse_trig;
    assign irq_events[IRQ_SEL]   = wr_en & (paddr == OFS_SEL);
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Terminal level checks
    a_unused_idle : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_UNUSED) |=> !term_out) else $error("unused terminal active");
    a_wobble_gate : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_WOBBLE_LIM && !ctrl_reg[CTRL_WOBBLE_EN]) |=> !term_out)
        else $error("wobble limit shown while disabled");
    a_wobble_lim : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_WOBBLE_LIM && ctrl_reg[CTRL_WOBBLE_EN] && sync2_reg.wobble_high)
        |=> term_out) else $error("wobble limit not shown");
    a_wobble_low : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_WOBBLE_LIM && ctrl_reg[CTRL_WOBBLE_EN] && sync2_reg.wobble_low)
        |=> term_out) else $error("low wobble limit not shown");
    a_wobble_idle : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_WOBBLE_LIM && !sync2_reg.wobble_high && !sync2_reg.wobble_low)
        |=> !term_out) else $error("wobble limit shown inside limits");
    a_plc_run : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_PLC_RUN) |=> (term_out == $past(sync2_reg.plc_running)))
        else $error("run status not followed");
    a_plc_pause : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_PLC_PAUSE) |=> (term_out == $past(sync2_reg.plc_paused)))
        else $error("pause status not followed");
    a_comm_follow : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_COMM) |=> (term_out == $past(ctrl_reg[CTRL_COMM_OUT])))
        else $error("comm output not followed");
    a_timer_follow : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_TIMER) |=> (term_out == $past(sync2_reg.timer_out)))
        else $error("timer output not followed");
    a_cnt_preset : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_CNT_PRESET) |=> (term_out == $past(sync2_reg.cnt_preset_reached)))
        else $error("preset count not followed");
    a_cnt_ind : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_CNT_IND) |=> (term_out == $past(sync2_reg.cnt_ind_reached)))
        else $error("indicating count not followed");
    a_unknown_idle : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg > SRC_CNT_IND || (sel_reg != SRC_UNUSED && sel_reg < SRC_WOBBLE_LIM))
        |=> !term_out) else $error("unknown code drives terminal");

    // Pulse source checks
    a_cycle_pulse : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_PLC_CYCLE && ev_cycle && $stable(sel_reg)) |=> ##1 term_out [*4])
        else $error("cycle pulse missing");
    a_step_pulse : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_PLC_STEP && ev_step) |=> pulse_out) else $error("step pulse missing");
    a_done_pulse : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_PLC_DONE && ev_done) |=> pulse_out) else $error("done pulse missing");
    a_time_pulse : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg == SRC_RUN_TIME && ev_time) |=> pulse_out) else $error("time pulse missing");
    a_pulse_route : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_reg inside {SRC_PLC_CYCLE, SRC_PLC_STEP, SRC_PLC_DONE, SRC_RUN_TIME})
        |=> (term_out == $past(pulse_out))) else $error("pulse not routed to terminal");
    a_pulse_quiet : assert property (@(posedge pclk) disable iff (!presetn)
        !(sel_reg inside {SRC_PLC_CYCLE, SRC_PLC_STEP, SRC_PLC_DONE, SRC_RUN_TIME})
        |-> !pulse_trig) else $error("level source started a pulse");
    a_pulse_restart : assert property (@(posedge pclk) disable iff (!presetn)
        (pulse_out && pulse_trig) |=> pulse_out) else $error("retrigger dropped the pulse");

    // Register and interrupt checks
    a_read_err : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !addr_ok) |-> pslverr) else $error("unmapped access not refused");
    a_read_ok : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && addr_ok) |-> !pslverr) else $error("mapped access refused");
    a_write_drop : assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && !addr_ok) |=> (sel_reg == $past(sel_reg)))
        else $error("unmapped write changed the selection");
    a_irq_clear : assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_IRQ_STAT && pwdata[IRQ_SEL]) |=> !irq_stat_reg[IRQ_SEL])
        else $error("select flag not cleared");
    a_sel_flag : assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == OFS_SEL) |=> irq_stat_reg[IRQ_SEL])
        else $error("select write not flagged");
    a_pulse_flag : assert property (@(posedge pclk) disable iff (!presetn)
        pulse_trig |=> irq_stat_reg[IRQ_PULSE]) else $error("pulse event not flagged");
    a_edge_flag : assert property (@(posedge pclk) disable iff (!presetn)
        (term_next && !term_reg) |=> irq_stat_reg[IRQ_EDGE])
        else $error("terminal rise not flagged");

    c_wobble  : cover property (@(posedge pclk) sel_reg == SRC_WOBBLE_LIM && term_out);
    c_pulse   : cover property (@(posedge pclk) pulse_trig ##1 pulse_out);
    c_restart : cover property (@(posedge pclk) pulse_out && pulse_trig);
    c_comm    : cover property (@(posedge pclk) sel_reg == SRC_COMM && term_out);
    c_irq     : cover property (@(posedge pclk) irq);

endmodule

// ==== rtl/term_sel_pkg.sv ====
// Purpose: Shared constants and types for the output terminal status selector
// Assumes: 50 MHz pclk
// Notes:   Register byte offsets, source codes and pulse timing live here
package term_sel_pkg;

    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned PULSE_MS      = 500;
    localparam int unsigned PULSE_CYCLES  = (CLK_HZ / 1000) * PULSE_MS;
    localparam int unsigned CNT_W         = 25;

    localparam logic [11:0] OFS_SEL       = 12'h000;
    localparam logic [11:0] OFS_CTRL      = 12'h004;
    localparam logic [11:0] OFS_STATUS    = 12'h008;
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h00c;
    localparam logic [11:0] OFS_IRQ_MASK  = 12'h010;

    localparam logic [5:0]  SEL_RESET     = 6'h00;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;
    localparam logic [2:0]  IRQ_RESET     = 3'h0;

    localparam int unsigned CTRL_WOBBLE_EN = 0;
    localparam int unsigned CTRL_COMM_OUT  = 1;

    localparam int unsigned IRQ_EDGE  = 0;
    localparam int unsigned IRQ_PULSE = 1;
    localparam int unsigned IRQ_SEL   = 2;

    typedef enum logic [5:0] {
        SRC_UNUSED      = 6'h00,
        SRC_WOBBLE_LIM  = 6'h0e,
        SRC_PLC_RUN     = 6'h0f,
        SRC_PLC_PAUSE   = 6'h10,
        SRC_PLC_CYCLE   = 6'h11,
        SRC_PLC_STEP    = 6'h12,
        SRC_PLC_DONE    = 6'h13,
        SRC_COMM        = 6'h14,
        SRC_RUN_TIME    = 6'h15,
        SRC_TIMER       = 6'h16,
        SRC_CNT_PRESET  = 6'h17,
        SRC_CNT_IND     = 6'h18
    } src_sel_t;

    typedef struct packed {
        logic wobble_high;
        logic wobble_low;
        logic plc_running;
        logic plc_paused;
        logic plc_cycle_done;
        logic plc_step_done;
        logic plc_all_done;
        logic run_time_reached;
        logic timer_out;
        logic cnt_preset_reached;
        logic cnt_ind_reached;
    } status_in_t;

endpackage

// ==== rtl/pulse_stretch.sv ====
// Purpose: Stretch a one-cycle event into a fixed-length pulse
// Assumes: Event input is synchronous to pclk
// Notes:   A fresh event restarts the count
`timescale 1ns/1ps
module pulse_stretch (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic trig,
    output logic      pulse
);
    import term_sel_pkg::*;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (trig) begin
            cnt_next = CNT_W'(PULSE_CYCLES);
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign pulse = (cnt_reg != '0);

    a_pulse_start : assert property (@(posedge pclk) disable iff (!presetn)
        trig |=> pulse) else $error("pulse did not start after event");
    a_pulse_hold : assert property (@(posedge pclk) disable iff (!presetn)
        trig |=> pulse [*8]) else $error("pulse ended too early");
    a_pulse_reload : assert property (@(posedge pclk) disable iff (!presetn)
        trig |=> (cnt_reg == CNT_W'(PULSE_CYCLES))) else $error("pulse timer not restarted");

endmodule

// ==== verification/term_load.sv ====
// Purpose: Load on the output terminal, relay coil or open-collector line
// Assumes: Terminal high means the output switch conducts
// Notes:   Coil follows one clock late; the line idles high through its pull-up
`timescale 1ns/1ps
module term_load (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic term_out,
    output logic      coil_on,
    output logic      oc_line
);
    // Pull-up holds the line high while the switch is open
    assign oc_line = ~term_out;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coil_on <= 1'b0;
        end else begin
            coil_on <= term_out;
        end
    end
endmodule

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the terminal status selector
// Assumes: APB slave answers through pready, 50 MHz pclk
// Notes:   500 ms pulses are checked at start and while held, not to their end
`timescale 1ns/1ps
module testbench;
    import term_sel_pkg::*;

    typedef struct packed {
        logic [5:0] sel;
        logic [1:0] ctrl;
        status_in_t st;
        logic       exp;
    } row_t;

    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0;
    status_in_t  status_in = '0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        term_out;
    logic        irq;
    logic        coil_on;
    logic        oc_line;
    logic        er;
    int          num_errors = 0;
    int          num_checks = 0;

    row_t rows [16] = '{
        '{6'h00, 2'h0, 11'h787, 1'b0}, '{6'h0e, 2'h1, 11'h400, 1'b1},
        '{6'h0e, 2'h1, 11'h200, 1'b1}, '{6'h0e, 2'h0, 11'h600, 1'b0},
        '{6'h0e, 2'h1, 11'h000, 1'b0}, '{6'h0f, 2'h0, 11'h100, 1'b1},
        '{6'h0f, 2'h0, 11'h687, 1'b0}, '{6'h10, 2'h0, 11'h080, 1'b1},
        '{6'h14, 2'h2, 11'h000, 1'b1}, '{6'h14, 2'h1, 11'h787, 1'b0},
        '{6'h16, 2'h0, 11'h004, 1'b1}, '{6'h16, 2'h0, 11'h783, 1'b0},
        '{6'h17, 2'h0, 11'h002, 1'b1}, '{6'h18, 2'h0, 11'h001, 1'b1},
        '{6'h18, 2'h0, 11'h786, 1'b0}, '{6'h1e, 2'h0, 11'h787, 1'b0}
    };
    logic [5:0] ev_code [4] = '{6'h11, 6'h12, 6'h13, 6'h15};
    status_in_t ev_bit  [4] = '{11'h040, 11'h020, 11'h010, 11'h008};

    always #10 pclk = ~pclk;

    term_sel i_dut (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .status_in (status_in),
        .term_out  (term_out),
        .irq       (irq)
    );

    term_load i_load (
        .pclk     (pclk),
        .presetn  (presetn),
        .term_out (term_out),
        .coil_on  (coil_on),
        .oc_line  (oc_line)
    );

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Called just after a rising edge; returns one edge after release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin
            num_errors++;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        num_errors++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge pclk);
        chk("reset term_out", term_out, 1'b0);
        chk("reset irq", irq, 1'b0);
        chk("reset pready", pready, 1'b1);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk($sformatf("reset reg %h", 4 * i), rd, 32'h0);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, 12'h020, 32'h0000003f);
        chk("unmapped write err", er, 1'b1);
        apb(1'b0, OFS_SEL, 32'h0);
        chk("unmapped write dropped", rd, 32'h0);
        apb(1'b1, OFS_SEL, 32'h0000000f);
        apb(1'b0, OFS_SEL, 32'h0);
        chk("sel readback", rd, 32'h0000000f);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("sel written flag", rd & 32'h4, 32'h4);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, OFS_IRQ_MASK, 32'h4);
        chk("irq unmasked", irq, 1'b1);
        apb(1'b1, OFS_IRQ_STAT, 32'h4);
        chk("irq cleared", irq, 1'b0);
        foreach (rows[i]) begin
            apb(1'b1, OFS_SEL, {26'h0, rows[i].sel});
            apb(1'b1, OFS_CTRL, {30'h0, rows[i].ctrl});
            status_in <= rows[i].st;
            repeat (6) @(posedge pclk);
            chk($sformatf("term row %0d", i), term_out, rows[i].exp);
            chk($sformatf("coil row %0d", i), coil_on, rows[i].exp);
            chk($sformatf("line row %0d", i), oc_line, !rows[i].exp);
        end
        status_in <= '0;
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_SEL, 32'h00000011);
        status_in <= 11'h020;
        repeat (6) @(posedge pclk);
        chk("other event ignored", term_out, 1'b0);
        status_in <= '0;
        repeat (2) @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            // Mid-run reset clears the previous 500 ms pulse
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            chk("mid reset term", term_out, 1'b0);
            presetn <= 1'b1;
            @(posedge pclk);
            apb(1'b1, OFS_SEL, {26'h0, ev_code[k]});
            repeat (2) @(posedge pclk);
            chk("pulse idle", term_out, 1'b0);
            status_in <= ev_bit[k];
            repeat (6) @(posedge pclk);
            chk("pulse start", term_out, 1'b1);
            status_in <= '0;
            repeat (1000) @(posedge pclk);
            chk("pulse hold", term_out, 1'b1);
        end
        status_in <= 11'h008;
        repeat (6) @(posedge pclk);
        chk("retrigger count", i_dut.u_pulse.cnt_reg, PULSE_CYCLES - 2);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("pulse active", rd[12], 1'b1);
        chk("retrigger term", term_out, 1'b1);
        apb(1'b1, OFS_SEL, 32'h0);
        repeat (2) @(posedge pclk);
        chk("unused over pulse", term_out, 1'b0);
        summarize();
    end
endmodule
